// [src/cla_pkg.sv]
/*
 * cla_pkg: shared constants and types for the control location arbiter.
 * assumes one 10 MHz control clock and a synchronous environment for the
 * digital command strobes.
 */
package cla_pkg;
	// arbiter states
	typedef enum logic [2:0] {
		CLA_MANUAL = 3'b000,
		CLA_REM_DIG = 3'b001,
		CLA_REM_ANA = 3'b010,
		CLA_LOCAL = 3'b011
	} cla_state_t;

	// control source identifiers: none, two digital interfaces, analog
	localparam int CLA_NUM_DIG = 2;
	localparam logic [1:0] CLA_SRC_NONE = 2'h0;
	localparam logic [1:0] CLA_SRC_USB = 2'h1;
	localparam logic [1:0] CLA_SRC_ETH = 2'h2;
	localparam logic [1:0] CLA_SRC_ANA = 2'h3;

	// set value layout
	localparam int CLA_SV_W = 16;
	localparam logic [CLA_SV_W-1:0] CLA_SV_RST = 16'h0000;

	// nonvolatile interface settings word and its factory default
	localparam int CLA_CFG_W = 16;
	localparam logic [CLA_CFG_W-1:0] CLA_CFG_DEFAULT = 16'h0000;

	// width of synchroniser chain for pins
	localparam int CLA_SYNC_W = 2;
endpackage

// [src/cla_sync.sv]
/*
 * cla_sync: two-stage synchroniser for asynchronous pin levels.
 * assumes the input is a slow level; the first stage feeds only the second.
 */
`timescale 1ns/100ps
module cla_sync (
	input wire logic mclk, // control clock
	input wire logic rst_n, // async reset, active low
	input wire logic rst_val, // unused reset hint kept constant-free
	input wire logic d_in, // asynchronous level
	output logic q_out // synchronised level
);
	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	// next values are plain shifts
	always_comb begin
		meta_nxt = d_in;
		sync_nxt = meta_r;
	end

	// reset to inactive high, matching an open pin
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign q_out = sync_r;
endmodule

// [src/cla_arbiter.sv]
/*
 * cla_arbiter: decides which control location commands the supply.
 * holds the granted source, the applied set values and the interface
 * settings; analog takeover and standby pins arrive asynchronously,
 * digital requests are one-cycle strobes on mclk.
 */
// Functional notes
// RULE_01: at most one remote source holds control
// RULE_02: digital request refused while analog pin low; in CLA_REM_DIG the owning digital interface's request is still granted
// RULE_03: analog pin ignored while digital holds control
// RULE_04: status reads always open to all
// RULE_05: manual state permits takeovers, no indicator
// RULE_06: remote indicator whenever any remote holds
// RULE_07: remote inhibit setting forces local lock
// RULE_08: local lock ends digital session for good
// RULE_09: local lock only suspends analog control
// RULE_10: set values kept across control handovers
// RULE_11: settings kept, factory default on reset command
// RULE_12: analog values honoured only after takeover pin
// RULE_13: standby pin gates output regardless of grant
// RULE_14: simultaneous requests favour analog, digital errors
`timescale 1ns/100ps
module cla_arbiter (
	input wire logic mclk, // 10 MHz control clock
	input wire logic rst_n, // async reset, active low
	input wire logic remote_pin_n, // analog takeover pin, low requests remote
	input wire logic output_standby_pin_n, // standby pin, low inhibits output
	input wire logic allow_remote, // setting: 1 permits remote control
	input wire logic [1:0] dig_req, // per digital interface: enter remote strobe
	input wire logic [1:0] dig_rel, // per digital interface: leave remote strobe
	input wire logic [1:0] dig_sv_we, // per digital interface: set value write
	input wire logic [15:0] dig_sv_data, // digital set value data
	input wire logic ana_sv_valid, // analog set value sample ready
	input wire logic [15:0] ana_sv_data, // analog set value sample
	input wire logic man_sv_we, // front panel set value write
	input wire logic [15:0] man_sv_data, // front panel set value data
	input wire logic out_on_req, // requested output state from controller
	input wire logic cfg_we, // interface settings write
	input wire logic [15:0] cfg_data, // interface settings data
	input wire logic factory_reset, // device reset command from setup menu
	output logic [2:0] loc_state, // current control location state
	output logic [1:0] ctrl_src, // granted source code
	output logic loc_remote, // remote indicator
	output logic loc_local, // local indicator
	output logic [1:0] dig_err, // per digital interface: refused request pulse
	output logic [1:0] dig_ack, // per digital interface: granted request pulse
	output logic [15:0] set_value, // applied set value, readable by all
	output logic [15:0] cfg_value, // interface settings, readable by all
	output logic out_enable // dc output enable
);
	cla_pkg::cla_state_t state_r;
	cla_pkg::cla_state_t state_nxt;
	logic [1:0] src_r;
	logic [1:0] src_nxt;
	logic [1:0] err_r;
	logic [1:0] err_nxt;
	logic [1:0] ack_r;
	logic [1:0] ack_nxt;
	logic rem_ind_r;
	logic rem_ind_nxt;
	logic loc_ind_r;
	logic loc_ind_nxt;
	logic [15:0] sv_r;
	logic [15:0] sv_nxt;
	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic oen_r;
	logic oen_nxt;
	logic ana_req_s;
	logic sb_s;

	// pins come from the isolated connector, so synchronise both
	cla_sync u_sync_rem (
		.mclk(mclk),
		.rst_n(rst_n),
		.rst_val(1'b1),
		.d_in(remote_pin_n),
		.q_out(ana_req_s)
	);

	cla_sync u_sync_sb (
		.mclk(mclk),
		.rst_n(rst_n),
		.rst_val(1'b1),
		.d_in(output_standby_pin_n),
		.q_out(sb_s)
	);

	// lowest-numbered digital interface wins a tie among digitals
	function automatic logic [1:0] first_src(input logic [1:0] req);
		logic [1:0] s;
		s = cla_pkg::CLA_SRC_NONE;
		if (req[0])
			s = cla_pkg::CLA_SRC_USB;
		else if (req[1])
			s = cla_pkg::CLA_SRC_ETH;
		return s;
	endfunction

	// one-hot mask of a digital source code
	function automatic logic [1:0] src_mask(input logic [1:0] s);
		logic [1:0] m;
		m = 2'h0;
		if (s == cla_pkg::CLA_SRC_USB)
			m = 2'h1;
		else if (s == cla_pkg::CLA_SRC_ETH)
			m = 2'h2;
		return m;
	endfunction

	// location state machine
	always_comb begin
		state_nxt = state_r;
		src_nxt = src_r;
		err_nxt = 2'h0;
		ack_nxt = 2'h0;
		case (state_r)
			cla_pkg::CLA_MANUAL: begin
				if (!allow_remote) begin
					state_nxt = cla_pkg::CLA_LOCAL; // RULE_07
					err_nxt = dig_req;
				end else if (!ana_req_s) begin
					// analog wins a same-cycle race
					state_nxt = cla_pkg::CLA_REM_ANA; // RULE_14
					src_nxt = cla_pkg::CLA_SRC_ANA; // RULE_01
					err_nxt = dig_req; // RULE_14
				end else if (dig_req != 2'h0) begin
					state_nxt = cla_pkg::CLA_REM_DIG; // RULE_05
					src_nxt = first_src(dig_req); // RULE_01
					ack_nxt = src_mask(first_src(dig_req));
					err_nxt = dig_req & ~src_mask(first_src(dig_req)); // RULE_01
				end
			end
			cla_pkg::CLA_REM_DIG: begin
				// pin changes are ignored here
				err_nxt = dig_req & ~src_mask(src_r); // RULE_03
				ack_nxt = dig_req & src_mask(src_r);
				if (!allow_remote) begin
					state_nxt = cla_pkg::CLA_LOCAL; // RULE_08
					src_nxt = cla_pkg::CLA_SRC_NONE; // RULE_08
					err_nxt = dig_req;
					ack_nxt = 2'h0;
				end else if ((dig_rel & src_mask(src_r)) != 2'h0) begin
					state_nxt = cla_pkg::CLA_MANUAL;
					src_nxt = cla_pkg::CLA_SRC_NONE;
				end
			end
			cla_pkg::CLA_REM_ANA: begin
				err_nxt = dig_req; // RULE_02
				if (!allow_remote) begin
					state_nxt = cla_pkg::CLA_LOCAL; // RULE_09
					src_nxt = cla_pkg::CLA_SRC_NONE;
				end else if (ana_req_s) begin
					state_nxt = cla_pkg::CLA_MANUAL;
					src_nxt = cla_pkg::CLA_SRC_NONE;
				end
			end
			cla_pkg::CLA_LOCAL: begin
				err_nxt = dig_req; // RULE_07
				if (allow_remote) begin
					if (!ana_req_s) begin
						// pin still asks for remote: resume analog
						state_nxt = cla_pkg::CLA_REM_ANA; // RULE_09
						src_nxt = cla_pkg::CLA_SRC_ANA;
					end else begin
						// digital must ask again
						state_nxt = cla_pkg::CLA_MANUAL; // RULE_08
						src_nxt = cla_pkg::CLA_SRC_NONE;
					end
				end
			end
			default: begin
				state_nxt = cla_pkg::CLA_MANUAL;
				src_nxt = cla_pkg::CLA_SRC_NONE;
			end
		endcase
		rem_ind_nxt = (state_nxt == cla_pkg::CLA_REM_DIG) || (state_nxt == cla_pkg::CLA_REM_ANA); // RULE_06
		loc_ind_nxt = (state_nxt == cla_pkg::CLA_LOCAL); // RULE_07
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= cla_pkg::CLA_MANUAL;
			src_r <= cla_pkg::CLA_SRC_NONE;
			err_r <= 2'h0;
			ack_r <= 2'h0;
			rem_ind_r <= 1'b0;
			loc_ind_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			src_r <= src_nxt;
			err_r <= err_nxt;
			ack_r <= ack_nxt;
			rem_ind_r <= rem_ind_nxt;
			loc_ind_r <= loc_ind_nxt;
		end
	end

	// set value: only the current owner writes; a handover alone changes nothing
	always_comb begin
		sv_nxt = sv_r; // RULE_10
		case (state_r)
			cla_pkg::CLA_MANUAL,
			cla_pkg::CLA_LOCAL: begin
				if (man_sv_we)
					sv_nxt = man_sv_data;
			end
			cla_pkg::CLA_REM_DIG: begin
				if ((dig_sv_we & src_mask(src_r)) != 2'h0)
					sv_nxt = dig_sv_data; // RULE_04
			end
			cla_pkg::CLA_REM_ANA: begin
				// samples only count once the pin has granted analog control
				if (ana_sv_valid)
					sv_nxt = ana_sv_data; // RULE_12
			end
			default: begin
				sv_nxt = sv_r;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			sv_r <= cla_pkg::CLA_SV_RST;
		else
			sv_r <= sv_nxt;
	end

	// settings word; the factory reset command beats a same-cycle write
	always_comb begin
		cfg_nxt = cfg_r;
		if (factory_reset)
			cfg_nxt = cla_pkg::CLA_CFG_DEFAULT; // RULE_11
		else if (cfg_we)
			cfg_nxt = cfg_data; // RULE_11
	end

	// note: true nonvolatility lives in the storage behind cfg_value
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cfg_r <= cla_pkg::CLA_CFG_DEFAULT;
		else
			cfg_r <= cfg_nxt;
	end

	// standby pin gates the output whatever the grant
	always_comb begin
		oen_nxt = out_on_req && sb_s; // RULE_13
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			oen_r <= 1'b0;
		else
			oen_r <= oen_nxt;
	end

	// status outputs stay readable in every state
	assign loc_state = state_r; // RULE_04
	assign ctrl_src = src_r;
	assign loc_remote = rem_ind_r;
	assign loc_local = loc_ind_r;
	assign dig_err = err_r;
	assign dig_ack = ack_r;
	assign set_value = sv_r;
	assign cfg_value = cfg_r;
	assign out_enable = oen_r;
endmodule

// [tb/cla_ana_ctl.sv]
/*
 * cla_ana_ctl: analog controller model on the isolated connector.
 * assumes the bench gives it plain levels just after mclk rises.
 */
`timescale 1ns/100ps
module cla_ana_ctl (
	input wire logic mclk, // control clock
	input wire logic take, // ask for analog control
	input wire logic sb, // 1 releases standby
	input wire logic sv_go, // send one set value
	input wire logic [15:0] sv, // value to send
	output logic remote_pin_n, // open collector, pulled up
	output logic output_standby_pin_n, // standby level
	output logic ana_sv_valid = 1'b0, // sample strobe
	output logic [15:0] ana_sv_data = 16'h0000 // sample
);
	logic [1:0] held_r = 2'h0;
	// a released collector floats up to manual
	assign remote_pin_n = take ? 1'b0 : 1'b1;
	assign output_standby_pin_n = sb;
	// values only once the takeover pin has stood low; idle data toggles
	always @(posedge mclk) begin
		held_r <= take ? {held_r[0], 1'b1} : 2'h0;
		ana_sv_valid <= sv_go && held_r == 2'h3;
		ana_sv_data <= (sv_go && held_r == 2'h3) ? sv : ~ana_sv_data;
	end
endmodule

// [tb/cla_arbiter_assertions.sv]
/*
 * cla_arbiter_assertions: port checks of the arbiter.
 * assumes the bind below and one mclk domain.
 */
`timescale 1ns/100ps
module cla_arbiter_assertions (
	input wire logic mclk, // clock
	input wire logic rst_n, // reset
	input wire logic output_standby_pin_n, // standby pin
	input wire logic allow_remote, // remote permit
	input wire logic [1:0] dig_req, // requests
	input wire logic [1:0] dig_rel, // releases
	input wire logic [1:0] dig_sv_we, // digital writes
	input wire logic man_sv_we, // panel write
	input wire logic ana_sv_valid, // analog write
	input wire logic factory_reset, // reset command
	input wire logic [2:0] loc_state, // state
	input wire logic [1:0] ctrl_src, // owner
	input wire logic loc_remote, // remote flag
	input wire logic loc_local, // local flag
	input wire logic [1:0] dig_err, // refusals
	input wire logic [1:0] dig_ack, // grants
	input wire logic [15:0] set_value, // applied value
	input wire logic [15:0] cfg_value, // settings
	input wire logic out_enable // output enable
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// pin needs two sync stages before the output register follows
	sequence s_sb_low; !output_standby_pin_n [*3]; endsequence
	a_one_src: assert property (loc_state == 3'h1 |-> ctrl_src inside {2'h1, 2'h2})
		else $error("digital state without digital owner");
	a_ack_owner: assert property (dig_ack[0] |-> ctrl_src == 2'h1 && loc_state == 3'h1)
		else $error("grant without ownership");
	a_ana_refuse: assert property (loc_state == 3'h2 && dig_req[0] |=> dig_err[0] && !dig_ack[0])
		else $error("digital request taken in analog");
	a_pin_ignored: assert property (loc_state == 3'h1 && allow_remote && dig_rel == 2'h0 |=> loc_state != 3'h2)
		else $error("analog took over digital session");
	a_manual_quiet: assert property (loc_state == 3'h0 |-> !loc_remote && !loc_local)
		else $error("indicator shown in manual");
	a_remote_flag: assert property (loc_remote == (loc_state inside {3'h1, 3'h2}))
		else $error("remote flag wrong");
	a_lock_enter: assert property (!allow_remote |=> loc_state == 3'h3 && loc_local && ctrl_src == 2'h0)
		else $error("lock not entered");
	a_sv_kept: assert property (!man_sv_we && dig_sv_we == 2'h0 && !ana_sv_valid |=> $stable(set_value))
		else $error("set value moved without write");
	a_cfg_default: assert property (factory_reset |=> cfg_value == cla_pkg::CLA_CFG_DEFAULT)
		else $error("settings not defaulted");
	a_sb_gate: assert property (s_sb_low |=> !out_enable)
		else $error("output on during standby");
endmodule
bind cla_arbiter cla_arbiter_assertions cla_chk (.mclk, .rst_n, .output_standby_pin_n, .allow_remote,
	.dig_req, .dig_rel, .dig_sv_we, .man_sv_we, .ana_sv_valid, .factory_reset, .loc_state, .ctrl_src,
	.loc_remote, .loc_local, .dig_err, .dig_ack, .set_value, .cfg_value, .out_enable);

// [tb/control_location_arbiter_tb_top.sv]
/*
 * control_location_arbiter_tb_top: table run of handovers, then odd cases.
 * assumes the analog model and the checker bind are compiled first.
 */
`timescale 1ns/100ps
module control_location_arbiter_tb_top;
	typedef struct packed {logic al, tk; logic [1:0] rq, rl; logic [2:0] st; logic [1:0] sr, ak, er;} cla_row_t;
	logic mclk = 1'b0, rst_n = 1'b0, allow_remote = 1'b1, take = 1'b0, sb = 1'b1, sv_go = 1'b0;
	logic man_sv_we = 1'b0, out_on_req = 1'b0, cfg_we = 1'b0, factory_reset = 1'b0;
	logic [1:0] dig_req = 2'h0, dig_rel = 2'h0, dig_sv_we = 2'h0, ctrl_src, dig_err, dig_ack;
	logic [15:0] dig_sv_data = 16'h0000, man_sv_data = 16'h0000, cfg_data = 16'h0000, sv = 16'h0000;
	logic [15:0] ana_sv_data, set_value, cfg_value;
	logic [2:0] loc_state;
	logic remote_pin_n, output_standby_pin_n, ana_sv_valid, loc_remote, loc_local, out_enable;
	int error_cnt = 0, compares = 0;
	// handover table: levels, strobes, then state, owner, grant, refusal
	cla_row_t rows [13] = '{'{1,0,1,0,1,1,1,0}, '{1,0,2,0,1,1,0,2}, '{1,1,0,0,1,1,0,0}, '{1,0,0,1,0,0,0,0},
		'{1,1,0,0,2,3,0,0}, '{1,1,1,0,2,3,0,1}, '{0,1,0,0,3,0,0,0}, '{1,1,0,0,2,3,0,0}, '{1,0,0,0,0,0,0,0},
		'{1,0,2,0,1,2,2,0}, '{0,0,0,0,3,0,0,0}, '{1,0,0,0,0,0,0,0}, '{1,0,3,0,1,1,1,2}};
	cla_arbiter cla_arbiter_inst (.mclk, .rst_n, .remote_pin_n, .output_standby_pin_n, .allow_remote, .dig_req,
		.dig_rel, .dig_sv_we, .dig_sv_data, .ana_sv_valid, .ana_sv_data, .man_sv_we, .man_sv_data, .out_on_req,
		.cfg_we, .cfg_data, .factory_reset, .loc_state, .ctrl_src, .loc_remote, .loc_local, .dig_err, .dig_ack,
		.set_value, .cfg_value, .out_enable);
	cla_ana_ctl cla_ana_ctl_inst (.mclk, .take, .sb, .sv_go, .sv, .remote_pin_n, .output_standby_pin_n,
		.ana_sv_valid, .ana_sv_data);
	always #50 mclk = ~mclk;
	// inputs move 10 ns after the edge so the design never races the bench
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge mclk);
			#10;
		end
	endtask
	// wide enough for the packed reset snapshot, so no field is cut off
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// pins need three edges to reach the state, so levels settle first
	task automatic step(input cla_row_t r);
		allow_remote = r.al;
		take = r.tk;
		cyc(3);
		dig_req = r.rq;
		dig_rel = r.rl;
		cyc(1);
		dig_req = 2'h0;
		dig_rel = 2'h0;
		chk("loc_state", r.st, loc_state);
		chk("ctrl_src", r.sr, ctrl_src);
		chk("dig_ack", r.ak, dig_ack);
		chk("dig_err", r.er, dig_err);
		chk("loc_remote", (r.st == 3'h1 || r.st == 3'h2), loc_remote);
		chk("loc_local", (r.st == 3'h3), loc_local);
	endtask
	// hang guard
	initial begin
		#1000000;
		error_cnt++;
		stop_test();
	end
	initial begin
		cyc(3);
		rst_n = 1'b1;
		chk("reset state", 16'h0000, {loc_state, ctrl_src, out_enable, set_value});
		for (int i = 0; i < 13; i++) step(rows[i]);
		// values survive a handover; only the owner writes
		step('{1,0,0,1,0,0,0,0});
		{man_sv_we, man_sv_data} = {1'b1, 16'h1234};
		cyc(1);
		man_sv_we = 1'b0;
		step('{1,0,1,0,1,1,1,0});
		chk("set_value", 16'h1234, set_value);
		{dig_sv_we, dig_sv_data, man_sv_we, man_sv_data} = {2'h1, 16'h5678, 1'b1, 16'h9999};
		cyc(1);
		{dig_sv_we, man_sv_we} = 3'h0;
		chk("set_value", 16'h5678, set_value);
		step('{1,0,0,1,0,0,0,0});
		// analog and digital arrive together
		take = 1'b1;
		cyc(2);
		dig_req = 2'h1;
		cyc(1);
		dig_req = 2'h0;
		chk("dig_err", 16'h0001, dig_err);
		chk("loc_state", 16'h0002, loc_state);
		{sv_go, sv} = {1'b1, 16'h0abc};
		cyc(1);
		sv_go = 1'b0;
		cyc(2);
		chk("set_value", 16'h0abc, set_value);
		{cfg_we, cfg_data} = {1'b1, 16'h00a5};
		cyc(1);
		chk("cfg_value", 16'h00a5, cfg_value);
		factory_reset = 1'b1;
		cyc(1);
		{cfg_we, factory_reset} = 2'h0;
		chk("cfg_value", cla_pkg::CLA_CFG_DEFAULT, cfg_value);
		out_on_req = 1'b1;
		cyc(4);
		chk("out_enable", 16'h0001, out_enable);
		sb = 1'b0;
		cyc(4);
		chk("out_enable", 16'h0000, out_enable);
		// mid-run reset while the pin still asks for analog control
		rst_n = 1'b0;
		cyc(1);
		chk("mid reset", 32'h0000_0000, {loc_state, ctrl_src, loc_remote, loc_local, dig_err, set_value});
		rst_n = 1'b1;
		cyc(3);
		chk("loc_state", 16'h0002, loc_state);
		chk("loc_remote", 16'h0001, loc_remote);
		stop_test();
	end
endmodule
